// >>> rtl/mcu8_consts.svh
// opcode patterns, reset values and expander codes for the 8-bit core
// assumes inclusion by the core files only
`ifndef MCU8_CONSTS_SVH
`define MCU8_CONSTS_SVH

// ----------------------------------------
// reset values and vectors
// ----------------------------------------
`define RST_PC 12'h000
`define IRQ_VEC 12'h003
`define RST_PORT 8'hFF
`define RST_BYTE 8'h00
`define ROM_AW_DEF 11
`define RAM_DEPTH_DEF 64

// ----------------------------------------
// expander command codes, sent on p2[3:2]
// ----------------------------------------
`define XP_READ 2'h0
`define XP_WRITE 2'h1
`define XP_OR 2'h2
`define XP_AND 2'h3

// ----------------------------------------
// opcodes and opcode patterns
// ----------------------------------------
`define OP_INS 8'h08
`define OP_OUTL_BUS 8'h02
`define OPZ_LOGIC_BUS 8'b100?1000
`define OPZ_LOGIC_P 8'b100?10??
`define OPZ_IN_P 8'b000010??
`define OPZ_OUTL_P 8'b001110??
`define OPZ_MOVX_RD 8'b1000000?
`define OPZ_MOVX_WR 8'b1001000?
`define OPZ_XP_RD 8'b000011??
`define OPZ_XP_WR 8'b001111??
`define OPZ_XP_LOGIC 8'b100?11??
`define OPZ_ALU_IMM 8'b????0011
`define OPZ_JMP 8'b???00100
`define OPZ_DECREMENT_JUMP_OP 8'b11101???
`define OPZ_MOV_RI 8'b10111???
`define OPZ_INC_R 8'b00011???
`define OPZ_INC_I 8'b0001000?
`define OPZ_DEC_R 8'b11001???
`define OP_PAGE_INDIRECT_JUMP_OP 8'hB3
`define OP_JC 8'hF6
`define OP_JNC 8'hE6
`define OP_JZ 8'hC6
`define OP_JNZ 8'h96
`define OP_JT0 8'h36
`define OP_JNT0 8'h26
`define OP_JT1 8'h56
`define OP_JNT1 8'h46
`define OP_JNI 8'h86
`define OP_EN_I 8'h05
`define OP_DIS_I 8'h15
`define OP_RETR 8'h93
`define OP_ENT0 8'h75
`define OP_START_COUNTER_OP 8'h45
`define OP_STOP 8'h65
`define OP_SEL_MB0 8'hE5
`define OP_SEL_MB1 8'hF5

`endif

// >>> rtl/mcu8_pkg.sv
// types shared by the core and its arithmetic unit
// assumes nothing of its surroundings
package mcu8_pkg;

	typedef enum logic [3:0] {
		ST_ALE = 4'b0001,
		ST_STB = 4'b0010,
		ST_EXE = 4'b0100,
		ST_STEP = 4'b1000
	} state_t;

	typedef enum logic [6:0] {
		CK_FETCH = 7'b0000001,
		CK_IMM = 7'b0000010,
		CK_RD = 7'b0000100,
		CK_WR = 7'b0001000,
		CK_XRD = 7'b0010000,
		CK_XWR = 7'b0100000,
		CK_INT = 7'b1000000
	} cyc_kind_t;

	typedef enum logic [3:0] {
		AL_PASS, AL_ADD, AL_ADC, AL_AND, AL_OR, AL_XOR, AL_INC, AL_DEC,
		AL_CLR, AL_CPL, AL_SWAP, AL_RL, AL_RLC, AL_RR, AL_RRC
	} alu_op_t;

endpackage : mcu8_pkg

// >>> rtl/mcu8_alu.sv
// accumulator arithmetic and logic unit
// assumes operands and carry are stable flops of the core
`timescale 1ns/100ps
module mcu8_alu import mcu8_pkg::*; (
	input wire alu_op_t op_i,
	input wire logic [7:0] a_i,
	input wire logic [7:0] b_i,
	input wire logic cy_i,
	output logic [7:0] res_o,
	output logic cy_o,
	output logic ac_o
);
	logic cin;
	logic [8:0] sum;
	logic [4:0] nib;

	assign cin = (op_i == AL_ADC) & cy_i;
	assign sum = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin};
	assign nib = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin};

	always_comb begin
		res_o = a_i;
		cy_o = cy_i;
		ac_o = 1'b0;
		case (op_i)
			AL_ADD, AL_ADC: begin
				res_o = sum[7:0];
				cy_o = sum[8];
				ac_o = nib[4];
			end
			AL_AND: res_o = a_i & b_i;
			AL_OR: res_o = a_i | b_i;
			AL_XOR: res_o = a_i ^ b_i;
			AL_INC: res_o = a_i + 8'h01;
			AL_DEC: res_o = a_i - 8'h01;
			AL_CLR: res_o = 8'h00;
			AL_CPL: res_o = ~a_i;
			AL_SWAP: res_o = {a_i[3:0], a_i[7:4]};
			AL_RL: res_o = {a_i[6:0], a_i[7]};
			AL_RLC: begin
				res_o = {a_i[6:0], cy_i};
				cy_o = a_i[7];
			end
			AL_RR: res_o = {a_i[0], a_i[7:1]};
			AL_RRC: begin
				res_o = {cy_i, a_i[7:1]};
				cy_o = a_i[0];
			end
			default: res_o = a_i;
		endcase
	end

endmodule : mcu8_alu

// >>> rtl/mcu8_core.sv
// 8-bit controller core: pin sequencing and instruction execution
// assumes synchronous pins, external pull-ups on ports, internal rom on ports
`timescale 1ns/100ps
`include "mcu8_consts.svh"
module mcu8_core import mcu8_pkg::*; #(
	parameter int ROM_AW = `ROM_AW_DEF,
	parameter int RAM_DEPTH = `RAM_DEPTH_DEF
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic external_access_in_i,
	input wire logic single_step_n_i,
	input wire logic int_n_i,
	input wire logic test_input_zero_i,
	output logic test_input_zero_o,
	output logic test_input_zero_oe_o,
	input wire logic test_input_one_i,
	input wire logic [7:0] bus_i,
	output logic [7:0] bus_o,
	output logic bus_oe_o,
	input wire logic [7:0] p1_i,
	output logic [7:0] p1_o,
	output logic [7:0] p1_oe_o,
	input wire logic [7:0] p2_i,
	output logic [7:0] p2_o,
	output logic [7:0] p2_oe_o,
	output logic ale_o,
	output logic program_store_strobe_n_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic expander_strobe_n_o,
	output logic [ROM_AW-1:0] rom_addr_o,
	input wire logic [7:0] rom_data_i,
	output logic [7:0] event_count_o
);
	localparam int RAW = $clog2(RAM_DEPTH);

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic cyc_kind_t cyc2(input logic [7:0] op);
		casez (op)
			`OP_INS, `OPZ_MOVX_RD: cyc2 = CK_RD;
			`OP_OUTL_BUS, `OPZ_MOVX_WR: cyc2 = CK_WR;
			`OPZ_XP_RD: cyc2 = CK_XRD;
			`OPZ_XP_WR, `OPZ_XP_LOGIC: cyc2 = CK_XWR;
			`OPZ_IN_P, `OPZ_OUTL_P: cyc2 = CK_INT;
			`OPZ_LOGIC_P, `OPZ_ALU_IMM, `OPZ_JMP, `OPZ_DECREMENT_JUMP_OP: cyc2 = CK_IMM;
			`OPZ_MOV_RI: cyc2 = CK_IMM;
			`OP_JC, `OP_JNC, `OP_JZ, `OP_JNZ, `OP_JT0, `OP_JNT0: cyc2 = CK_IMM;
			`OP_JT1, `OP_JNT1, `OP_JNI: cyc2 = CK_IMM;
			default: cyc2 = CK_FETCH;
		endcase
	endfunction : cyc2

	function automatic alu_op_t alu_sel(input logic [7:0] op);
		alu_sel = AL_PASS;
		if (op[3:0] == 4'h7) begin
			case (op[7:4])
				4'h0: alu_sel = AL_DEC;
				4'h1: alu_sel = AL_INC;
				4'h2: alu_sel = AL_CLR;
				4'h3: alu_sel = AL_CPL;
				4'h4: alu_sel = AL_SWAP;
				4'h6: alu_sel = AL_RRC;
				4'h7: alu_sel = AL_RR;
				4'hE: alu_sel = AL_RL;
				4'hF: alu_sel = AL_RLC;
				default: alu_sel = AL_PASS;
			endcase
		end else if (op[3] || op[3:1] == 3'h0 || op[3:0] == 4'h3) begin
			case (op[7:4])
				4'h0, 4'h6: alu_sel = (op[3:0] == 4'h3) == (op[7:4] == 4'h0) ? AL_ADD : AL_PASS;
				4'h1, 4'h7: alu_sel = (op[3:0] == 4'h3) == (op[7:4] == 4'h1) ? AL_ADC : AL_PASS;
				4'h4: alu_sel = AL_OR;
				4'h5: alu_sel = AL_AND;
				4'hD: alu_sel = AL_XOR;
				default: alu_sel = AL_PASS;
			endcase
		end
	endfunction : alu_sel

	// ----------------------------------------
	// state
	// ----------------------------------------
	state_t st;
	cyc_kind_t kind;
	logic [11:0] pc, ret_pc;
	logic [7:0] ir, din, acc, p1, p2, bus_latch;
	logic cy, ac, bus_static, ien, in_svc, t0_clk_en, cnt_en, t1_prev, dbf, t0_div;
	logic [7:0] evt;
	logic [7:0] ram [RAM_DEPTH];

	// ----------------------------------------
	// datapath wires
	// ----------------------------------------
	wire is_fetch = kind == CK_FETCH;
	wire is_imm = kind == CK_IMM;
	wire expander_strobe_cyc = is_fetch | is_imm;
	wire is_xp = kind == CK_XRD || kind == CK_XWR;
	wire is_page_indirect_jump_op = ir == `OP_PAGE_INDIRECT_JUMP_OP;
	wire is_jmp = ir[4:0] == 5'h04;
	wire is_decrement_jump_op = ir[7:3] == 5'b11101;
	wire is_movx = ir[7:1] == 7'b1000000 || ir[7:1] == 7'b1001000;
	wire [7:0] xptr = ram[RAW'(ir[0])];
	wire [RAW-1:0] reg_idx = ir[3] ? RAW'(ir[2:0]) : xptr[RAW-1:0];
	wire [7:0] rv = ram[reg_idx];
	wire [11:0] faddr = (is_imm && is_page_indirect_jump_op) ? {pc[11:8], acc} : pc;
	wire ext_fetch = external_access_in_i | (|faddr[11:ROM_AW]);
	wire in_ale = st == ST_ALE;
	wire in_stb = st == ST_STB;
	wire exe = st == ST_EXE;
	wire cyc_kind_t two = cyc2(ir);
	wire single = exe & is_fetch & (two == CK_FETCH);
	wire fin = exe & ~(is_fetch & (two != CK_FETCH));
	wire last2 = exe & ~is_fetch;
	wire alu_op_t asel = alu_sel(ir);
	wire alu_go = (single | (last2 & is_imm)) & (asel != AL_PASS);
	wire upd_cy = asel == AL_ADD || asel == AL_ADC || asel == AL_RLC || asel == AL_RRC;
	wire [7:0] dec_v = rv - 8'h01;
	wire inc_op = ir[7:3] == 5'b00011 || ir[7:1] == 7'b0001000;
	wire is_mov_ri = ir[7:3] == 5'b10111;
	wire ram_we = (single & (inc_op | ir[7:3] == 5'b11001))
		| (last2 & is_imm & (is_decrement_jump_op | is_mov_ri));
	wire [7:0] ram_wd = is_mov_ri ? din : (inc_op ? rv + 8'h01 : dec_v);
	wire [1:0] xcmd = ir[5] ? `XP_WRITE : (ir[7] ? (ir[4] ? `XP_AND : `XP_OR) : `XP_READ);
	wire [7:0] pin_v = ir[1] ? p2_i : p1_i;
	wire [7:0] alu_res;
	wire alu_cy, alu_ac;
	logic cond;

	always_comb begin
		case (ir)
			`OP_JC: cond = cy;
			`OP_JNC: cond = ~cy;
			`OP_JZ: cond = acc == 8'h00;
			`OP_JNZ: cond = acc != 8'h00;
			`OP_JT0: cond = test_input_zero_i;
			`OP_JNT0: cond = ~test_input_zero_i;
			`OP_JT1: cond = test_input_one_i;
			`OP_JNT1: cond = ~test_input_one_i;
			`OP_JNI: cond = ~int_n_i;
			default: cond = 1'b0;
		endcase
	end

	wire jump_take = last2 & is_imm & (is_jmp | is_page_indirect_jump_op | cond | (is_decrement_jump_op & dec_v != 8'h00));
	wire [11:0] jump_pc = is_jmp ? {dbf, ir[7:5], din} : {pc[11:8], din};
	wire [11:0] tgt_pc = jump_take ? jump_pc : ((last2 && ir == `OP_RETR) ? ret_pc : pc);
	wire irq_take = fin & ien & ~int_n_i & ~in_svc;

	mcu8_alu u_alu (
		.op_i(asel),
		.a_i(acc),
		.b_i(is_imm ? din : rv),
		.cy_i(cy),
		.res_o(alu_res),
		.cy_o(alu_cy),
		.ac_o(alu_ac)
	);

	// ----------------------------------------
	// pin drive
	// ----------------------------------------
	// one ale per machine cycle
	assign ale_o = in_ale;
	assign program_store_strobe_n_o = ~(in_stb & expander_strobe_cyc & ext_fetch);
	assign rd_n_o = ~(in_stb & kind == CK_RD);
	assign wr_n_o = ~(in_stb & kind == CK_WR);
	assign expander_strobe_n_o = ~(in_stb & is_xp);
	assign rom_addr_o = faddr[ROM_AW-1:0];

	wire bus_adr = in_ale & ((expander_strobe_cyc & ext_fetch) | (is_movx & kind != CK_INT));
	wire bus_dat = in_stb & kind == CK_WR;
	assign bus_oe_o = bus_adr | bus_dat | (bus_static & ~(in_stb & (kind == CK_RD | expander_strobe_cyc & ext_fetch)));
	assign bus_o = bus_adr ? (expander_strobe_cyc ? faddr[7:0] : xptr) : (bus_dat ? acc : bus_latch);

	// pc high bits and expander bus
	wire p2_lo_drv = (in_ale & ((expander_strobe_cyc & ext_fetch) | is_xp)) | (in_stb & kind == CK_XWR);
	wire [3:0] p2_lo_v = in_ale ? (is_xp ? {xcmd, ir[1:0]} : faddr[11:8]) : acc[3:0];
	wire p2_lo_rel = in_stb & kind == CK_XRD;
	assign p1_o = p1;
	assign p1_oe_o = ~p1;
	assign p2_o = {p2[7:4], p2_lo_drv ? p2_lo_v : p2[3:0]};
	assign p2_oe_o = {~p2[7:4], p2_lo_drv ? 4'hF : (p2_lo_rel ? 4'h0 : ~p2[3:0])};
	assign test_input_zero_o = t0_div;
	assign test_input_zero_oe_o = t0_clk_en;
	assign event_count_o = evt;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	wire [7:0] cap = expander_strobe_cyc ? (ext_fetch ? bus_i : rom_data_i)
		: (kind == CK_XRD ? {4'h0, p2_i[3:0]} : bus_i);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= ST_ALE;
			kind <= CK_FETCH;
			ir <= `RST_BYTE;
			din <= `RST_BYTE;
		end else begin
			unique case (st)
				ST_ALE: st <= ST_STB;
				ST_STB: begin
					st <= ST_EXE;
					if (is_fetch) ir <= cap;
					else din <= cap;
				end
				ST_EXE: begin
					st <= ST_ALE;
					kind <= (is_fetch && two != CK_FETCH) ? two : CK_FETCH;
					if (fin && !single_step_n_i) st <= ST_STEP;
				end
				ST_STEP: if (single_step_n_i) st <= ST_ALE;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pc <= `RST_PC;
			ret_pc <= `RST_PC;
			in_svc <= 1'b0;
		end else if (in_stb && expander_strobe_cyc && !(is_imm && is_page_indirect_jump_op)) begin
			pc <= pc + 12'h001;
		end else if (fin) begin
			pc <= irq_take ? `IRQ_VEC : tgt_pc;
			if (irq_take) ret_pc <= tgt_pc;
			if (irq_take) in_svc <= 1'b1;
			else if (last2 && ir == `OP_RETR) in_svc <= 1'b0;
		end
	end

	// ----------------------------------------
	// accumulator, flags, memory
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc <= `RST_BYTE;
			cy <= 1'b0;
			ac <= 1'b0;
		end else if (alu_go) begin
			acc <= alu_res;
			if (upd_cy) cy <= alu_cy;
			if (asel == AL_ADD || asel == AL_ADC) ac <= alu_ac;
		end else if (last2 && (kind == CK_RD || kind == CK_XRD)) begin
			acc <= din;
		end else if (last2 && kind == CK_INT && !ir[5]) begin
			acc <= pin_v;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < RAM_DEPTH; i++) ram[i] <= `RST_BYTE;
		end else if (ram_we) begin
			ram[reg_idx] <= ram_wd;
		end
	end

	// ----------------------------------------
	// ports and bus latch
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			p1 <= `RST_PORT;
			p2 <= `RST_PORT;
			bus_latch <= `RST_BYTE;
			bus_static <= 1'b0;
		end else if (last2) begin
			if ((is_imm && ir[7:5] == 3'b100 && ir[3:2] == 2'b10 && ir[1:0] != 2'b00)
				|| (kind == CK_INT && ir[5])) begin
				if (ir[0]) p1 <= kind == CK_INT ? acc : (ir[4] ? p1 & din : p1 | din);
				else p2 <= kind == CK_INT ? acc : (ir[4] ? p2 & din : p2 | din);
			end
			if (is_imm && ir[7:4] == 4'h8 && ir[3:0] == 4'h8) begin
				bus_latch <= bus_latch | din;
				bus_static <= 1'b1;
			end
			if (is_imm && ir == 8'h98) begin
				bus_latch <= bus_latch & din;
				bus_static <= 1'b1;
			end
			if (kind == CK_WR && ir == `OP_OUTL_BUS) begin
				bus_latch <= acc;
				bus_static <= 1'b1;
			end
			if (kind == CK_RD) bus_static <= 1'b0;
		end
	end

	// ----------------------------------------
	// control flags, t0 clock, t1 counter
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ien <= 1'b0;
			t0_clk_en <= 1'b0;
			cnt_en <= 1'b0;
			dbf <= 1'b0;
		end else if (single) begin
			if (ir == `OP_EN_I) ien <= 1'b1;
			if (ir == `OP_DIS_I) ien <= 1'b0;
			if (ir == `OP_ENT0) t0_clk_en <= 1'b1;
			if (ir == `OP_START_COUNTER_OP) cnt_en <= 1'b1;
			if (ir == `OP_STOP) cnt_en <= 1'b0;
			if (ir == `OP_SEL_MB0) dbf <= 1'b0;
			if (ir == `OP_SEL_MB1) dbf <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			t0_div <= 1'b0;
			t1_prev <= 1'b0;
			evt <= `RST_BYTE;
		end else begin
			t0_div <= t0_clk_en & ~t0_div;
			t1_prev <= test_input_one_i;
			if (cnt_en && t1_prev && !test_input_one_i) evt <= evt + 8'h01;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	chk_store_only_fetch: assert property (!program_store_strobe_n_o |-> expander_strobe_cyc && ext_fetch && rd_n_o) else $error("store strobe outside fetch");
	chk_ale_once_cycle: assert property ($rose(ale_o) |=> !ale_o [*2]) else $error("ale twice in a cycle");
	chk_read_releases: assert property (!rd_n_o |-> !bus_oe_o && wr_n_o) else $error("bus driven during read");
	chk_write_data: assert property (!wr_n_o |-> bus_oe_o && bus_o == acc) else $error("write data wrong");
	chk_fetch_addr: assert property (ale_o && is_fetch && ext_fetch |-> bus_oe_o && bus_o == pc[7:0] && p2_o[3:0] == pc[11:8] ##1 !program_store_strobe_n_o) else $error("fetch address wrong");
	chk_irq_enabled: assert property ($rose(in_svc) |-> $past(ien) && pc == `IRQ_VEC) else $error("interrupt while disabled");
	chk_step_holds: assert property (st == ST_STEP && !single_step_n_i |=> st == ST_STEP && !ale_o) else $error("ran while stepping");
	chk_quasi_low: assert property (((p1_oe_o & p1_o) == 8'h00) && ((p2_oe_o[7:4] & p2_o[7:4]) == 4'h0)) else $error("port driven high");
	chk_ea_forces: assert property (external_access_in_i && in_stb && expander_strobe_cyc |-> !program_store_strobe_n_o) else $error("internal fetch under ea");
	chk_xp_strobe: assert property (!expander_strobe_n_o |-> $past(ale_o) && $past(p2_oe_o[3:0]) == 4'hF) else $error("expander strobe without command");

	cov_ext_fetch: cover property (!program_store_strobe_n_o);
	cov_data_write: cover property (!wr_n_o && is_movx);
	cov_xp_read: cover property (!expander_strobe_n_o && kind == CK_XRD);
	cov_irq: cover property (irq_take);

endmodule : mcu8_core

// >>> test/mcu8_ext_model.sv
// external program memory, data memory and 4-bit expander for the core
// assumes the bench resolves port pins and loads expander_strobe before reset ends
`timescale 1ns/100ps
module mcu8_ext_model (
	input wire logic clk_i,
	input wire logic ale_i,
	input wire logic program_store_strobe_n_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic xs_n_i,
	input wire logic [7:0] dbus_i,
	input wire logic bus_oe_i,
	input wire logic [7:0] p2_i,
	output logic [7:0] bus_o,
	output logic [3:0] nib_o
);
	logic [7:0] expander_strobe [0:255];
	logic [7:0] xdata [0:255];
	logic [3:0] xp [0:3];
	logic [7:0] wq [$];
	logic [7:0] wa [$];
	logic [7:0] addr = 8'h00;
	logic [7:0] last = 8'h00;
	logic [3:0] xc = 4'h0;
	// ----------------------------------------
	// pins seen by the core
	// ----------------------------------------
	// released bus shows the inverse of its last level
	assign bus_o = bus_oe_i ? dbus_i : (!program_store_strobe_n_i ? expander_strobe[addr] :
		(!rd_n_i ? xdata[addr] : ~last));
	assign nib_o = (!xs_n_i && xc[3:2] == 2'h0) ? xp[xc[1:0]] : 4'hF;
	// ----------------------------------------
	// capture side
	// ----------------------------------------
	// address taken at ale
	always @(posedge clk_i) begin
		last <= bus_o;
		if (ale_i) begin
			addr <= dbus_i;
			xc <= p2_i[3:0];
		end
		if (!wr_n_i) begin
			wq.push_back(dbus_i);
			wa.push_back(addr);
		end
		if (!xs_n_i && xc[3:2] == 2'h1) xp[xc[1:0]] <= p2_i[3:0];
		if (!xs_n_i && xc[3:2] == 2'h2) xp[xc[1:0]] <= xp[xc[1:0]] | p2_i[3:0];
		if (!xs_n_i && xc[3:2] == 2'h3) xp[xc[1:0]] <= xp[xc[1:0]] & p2_i[3:0];
	end
endmodule : mcu8_ext_model

// >>> test/mcu8_core_bus_and_alu_ops_test.sv
// self-checking bench for the core running a program from external memory
// assumes the external model above and the core's pin contract
`timescale 1ns/100ps
`define CHECK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin miscompares++; \
	$display("wrong value %s expected %h seen %h", nm, ex, got); end end
module mcu8_core_bus_and_alu_ops_test;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic ss_n = 1'b1;
	logic int_n = 1'b1;
	logic t1 = 1'b0;
	int miscompares = 0;
	int check_count = 0;
	int pc = 0;
	logic [7:0] ew [$];
	wire logic t0_o, t0_oe, bus_oe, ale, program_store_strobe_n, rd_n, wr_n, xs_n;
	wire logic [7:0] bus_o, bus_in, p1_o, p1_oe, p2_o, p2_oe, p2_pin, cnt;
	wire logic [3:0] nib;
	wire logic [10:0] rom_a;
	assign p2_pin = (p2_o & p2_oe) | ({4'hF, nib} & ~p2_oe);
	always #20 clk_i = ~clk_i;
	mcu8_core dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .external_access_in_i(1'b1),
		.single_step_n_i(ss_n), .int_n_i(int_n), .test_input_zero_i(t0_oe & t0_o),
		.test_input_zero_o(t0_o), .test_input_zero_oe_o(t0_oe), .test_input_one_i(t1),
		.bus_i(bus_in), .bus_o(bus_o), .bus_oe_o(bus_oe), .p1_i(p1_o | ~p1_oe),
		.p1_o(p1_o), .p1_oe_o(p1_oe), .p2_i(p2_pin), .p2_o(p2_o), .p2_oe_o(p2_oe),
		.ale_o(ale), .program_store_strobe_n_o(program_store_strobe_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
		.expander_strobe_n_o(xs_n), .rom_addr_o(rom_a), .rom_data_i(rom_a[7:0] ^ 8'hA5),
		.event_count_o(cnt));
	mcu8_ext_model u_ext (.clk_i(clk_i), .ale_i(ale), .program_store_strobe_n_i(program_store_strobe_n), .rd_n_i(rd_n),
		.wr_n_i(wr_n), .xs_n_i(xs_n), .dbus_i(bus_o), .bus_oe_i(bus_oe), .p2_i(p2_pin),
		.bus_o(bus_in), .nib_o(nib));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [8:0] adc(input logic [7:0] a, b, input logic c);
		return {1'b0, a} + {1'b0, b} + {8'h00, c};
	endfunction : adc
	task put(input logic [7:0] b);
		u_ext.expander_strobe[pc] = b;
		pc++;
	endtask : put
	task count_ale(input int cyc, output int n);
		n = 0;
		repeat (cyc) begin
			@(negedge clk_i);
			n += int'(ale === 1'b1);
		end
	endtask : count_ale
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	always @(negedge clk_i) begin
		int_n <= 1'($urandom);
		t1 <= 1'($urandom);
	end
	always @(negedge clk_i) begin
		if (rst_n_i && !program_store_strobe_n && !(rd_n & wr_n & xs_n)) `CHECK("strobes", 1'b1, 1'b0)
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [7:0] x, y, z, r, m, o, d, a, p1e;
		logic [8:0] s;
		logic [3:0] x2, x3;
		int n, lp, k;
		void'($urandom(32'hA96A));
		{x, y, z, r} = $urandom;
		{m, o, d} = 24'($urandom);
		n = 1 + int'($urandom % 4);
		for (int i = 0; i < 256; i++) begin
			u_ext.expander_strobe[i] = 8'h00;
			u_ext.xdata[i] = 8'($urandom);
		end
		for (int i = 0; i < 4; i++) u_ext.xp[i] = 4'($urandom);
		put(8'h27); put(8'h03); put(x); put(8'h02); ew.push_back(x);
		s = adc(x, y, 1'b0);
		put(8'h13); put(y); put(8'h02); ew.push_back(s[7:0]);
		s = adc(s[7:0], z, s[8]);
		put(8'h13); put(z); put(8'h02); ew.push_back(s[7:0]);
		s = adc(s[7:0], r, 1'b0);
		put(8'hB9); put(r); put(8'h69); put(8'h02); ew.push_back(s[7:0]);
		a = s[7:0] ^ r; put(8'hD9); put(8'h02); ew.push_back(a);
		a = a & r; put(8'h59); put(8'h02); ew.push_back(a);
		a = a | r; put(8'h49); put(8'h02); ew.push_back(a);
		p1e = (a & m) | o; put(8'h39); put(8'h99); put(m); put(8'h89); put(o);
		a = {4'h0, u_ext.xp[1]}; put(8'h0D); put(8'h02); ew.push_back(a);
		a = u_ext.xdata[d]; put(8'hB8); put(d); put(8'h80); put(8'h02); ew.push_back(a);
		a = a + 8'h01; put(8'h17); put(8'h90); ew.push_back(a);
		x2 = u_ext.xp[2] & a[3:0]; x3 = u_ext.xp[3] | a[3:0]; put(8'h9E); put(8'h8F);
		put(8'hBA); put(8'(n)); lp = pc; put(8'h17); put(8'hEA); put(8'(lp)); put(8'h02);
		a = a + 8'(n); ew.push_back(a);
		put(8'h27); put(8'h03); put(8'hF0); put(8'hB3); ew.push_back(8'hF0);
		u_ext.expander_strobe[8'hF0] = 8'hE0; u_ext.expander_strobe[8'hE0] = 8'h02;
		u_ext.expander_strobe[8'hE1] = 8'h04; u_ext.expander_strobe[8'hE2] = 8'hE1;
		repeat (5) @(negedge clk_i);
		rst_n_i = 1'b1;
		for (k = 0; k < 3000 && u_ext.wq.size() < ew.size(); k++) @(negedge clk_i);
		if (k == 3000) begin
			miscompares++;
			$display("wrong value writes expected %0d seen %0d", ew.size(), u_ext.wq.size());
		end else begin
			foreach (ew[i]) `CHECK("bus write", ew[i], u_ext.wq[i])
			`CHECK("movx addr", d, u_ext.wa[9])
			`CHECK("port1", p1e, p1_o)
			`CHECK("exp and", x2, u_ext.xp[2])
			`CHECK("exp or", x3, u_ext.xp[3])
			`CHECK("counter", 8'h00, cnt)
			`CHECK("t0 drive", 1'b0, t0_oe)
			count_ale(30, k);
			`CHECK("ale run", 10, k)
			ss_n = 1'b0;
			repeat (9) @(negedge clk_i);
			count_ale(30, k);
			`CHECK("ale stop", 0, k)
			ss_n = 1'b1;
			count_ale(6, k);
			`CHECK("ale resume", 1'b1, k > 0)
		end
		report_and_stop;
	end
endmodule : mcu8_core_bus_and_alu_ops_test
